// ### acp_chan_post.sv
// Overview of operation
// - Gain enable set: channel 8 scaled by code times 0.2 dB, bits 15-11.
// - Offset enable set: add channel 8 signed ten-bit offset, 14-bit LSB.
// - Offset copy register holds the same ten-bit offset in bits 9-0.
// - Pattern select set: PRBS replaces outputs 5-8, enables bits 15-12.
// - Pattern select set: output 5 coded by bits 11-9, output 6 by 8-6.
// - Enabled high-pass on channels 5-8 uses shared k in bits 4-1.
// - Bit 0 enables the high-pass; zero, the reset value, bypasses it.
`timescale 1ns/100ps
module acp_chan_post
  import acp_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     sample_valid,
  input  wire logic signed [ACP_DW-1:0] chan5_sample,
  input  wire logic signed [ACP_DW-1:0] chan6_sample,
  input  wire logic signed [ACP_DW-1:0] chan7_sample,
  input  wire logic signed [ACP_DW-1:0] chan8_sample,
  output logic                          out_valid,
  output logic signed [ACP_DW-1:0]      out5_data,
  output logic signed [ACP_DW-1:0]      out6_data,
  output logic signed [ACP_DW-1:0]      out7_data,
  output logic signed [ACP_DW-1:0]      out8_data
);

  // ****************************************************************
  // Register file and bus slave.
  // ****************************************************************

  logic [15:0]  gain_ofs_r;
  logic [15:0]  ofs_copy_r;
  logic [15:0]  pat_hpf_r;
  logic [2:0]   ctrl_r;
  logic         pready_r;
  logic         pslverr_r;
  logic [31:0]  prdata_r;
  logic [5:0]   idx;
  logic [15:0]  wdata16;
  logic         wr_acc;
  logic         setup;
  logic [31:0]  rd_word;
  logic         rd_hit;
  logic         mism;
  logic signed [ACP_DW-1:0] out_r [4];

  // Byte address to word index; access completes on the second cycle.
  assign idx     = paddr[7:2];
  assign wdata16 = pwdata[15:0];
  assign setup   = psel && !penable;
  assign wr_acc  = psel && penable && pready_r && pwrite;
  assign mism    = gain_ofs_r[ACP_OFS_HI:ACP_OFS_LO]
                   != ofs_copy_r[ACP_OFS_HI:ACP_OFS_LO];

  // Selects the read word; unmapped indices answer with an error.
  always_comb
  begin
    rd_word = '0;
    rd_hit  = 1'b1;
    case (idx)
      ACP_IDX_GAIN_OFS: rd_word[15:0] = gain_ofs_r;
      ACP_IDX_OFS_COPY: rd_word[15:0] = ofs_copy_r;
      ACP_IDX_PAT_HPF:  rd_word[15:0] = pat_hpf_r;
      ACP_IDX_CTRL:     rd_word[2:0]  = ctrl_r;
      ACP_IDX_STAT:
      begin
        rd_word[ACP_DW-1:0]  = out_r[3];
        rd_word[ACP_ST_MISM] = mism;
      end
      default:          rd_hit = 1'b0;
    endcase
  end

  // Prepares the answer during setup so it is ready for the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end
    else if (setup)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= !rd_hit;
      prdata_r  <= pwrite ? '0 : rd_word;
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // Stores the writable registers at the completing access edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_ofs_r <= ACP_REG_RST;
      ofs_copy_r <= ACP_REG_RST;
      pat_hpf_r  <= ACP_REG_RST;
      ctrl_r     <= ACP_CTRL_RST;
    end
    else if (wr_acc)
    begin
      case (idx)
        ACP_IDX_GAIN_OFS: gain_ofs_r <= wdata16;
        ACP_IDX_OFS_COPY: ofs_copy_r <= wdata16;
        ACP_IDX_PAT_HPF:  pat_hpf_r  <= wdata16;
        ACP_IDX_CTRL:     ctrl_r     <= wdata16[2:0];
        default:          ;
      endcase
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // Field decode.
  // ****************************************************************

  logic       gain_en;
  logic       ofs_en;
  logic       pat_sel;
  logic       hpf_en;
  logic [3:0] hpf_k;
  logic [3:0] prbs_en;
  logic [2:0] code5;
  logic [2:0] code6;

  // Control bits steering the datapath.
  assign gain_en = ctrl_r[ACP_CTL_GAIN];
  assign ofs_en  = ctrl_r[ACP_CTL_OFS];
  assign pat_sel = ctrl_r[ACP_CTL_PSEL];
  assign hpf_en  = pat_hpf_r[ACP_HPF_EN];
  assign hpf_k   = pat_hpf_r[ACP_K_HI:ACP_K_LO];
  assign code5   = pat_hpf_r[ACP_PAT5_HI:ACP_PAT5_LO];
  assign code6   = pat_hpf_r[ACP_PAT6_HI:ACP_PAT6_LO];

  // PRBS enables, index 0 for output 5 down to index 3 for output 8.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      prbs_en[i] = pat_hpf_r[ACP_PRBS5 - i];
  end

  // ****************************************************************
  // Stage one: channel 8 gain and offset, others delayed to match.
  // ****************************************************************

  logic signed [ACP_DW-1:0] dly_r [3];
  logic signed [ACP_DW-1:0] ch8_g;
  logic                     s1_valid;
  logic signed [ACP_DW-1:0] hpf_in [4];

  // Holds channels 5 to 7 for the cycle channel 8 spends in its stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 3; i++)
        dly_r[i] <= '0;
    end
    else if (sample_valid)
    begin
      dly_r[0] <= chan5_sample;
      dly_r[1] <= chan6_sample;
      dly_r[2] <= chan7_sample;
    end
  end

  acp_gain_offset u_gain8 (
    .clk       (pclk),
    .rst_n     (presetn),
    .valid_in  (sample_valid),
    .din       (chan8_sample),
    .gain_en   (gain_en),
    .ofs_en    (ofs_en),
    .gain_code (gain_ofs_r[ACP_GAIN_HI:ACP_GAIN_LO]),
    .ofs       (gain_ofs_r[ACP_OFS_HI:ACP_OFS_LO]),
    .valid_out (s1_valid),
    .dout      (ch8_g)
  );

  // Gathers the four filter inputs.
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      hpf_in[i] = dly_r[i];
    hpf_in[3] = ch8_g;
  end

  // ****************************************************************
  // Stage two: shared high-pass setting on channels 5 to 8.
  // ****************************************************************

  logic [3:0]               hv;
  logic signed [ACP_DW-1:0] hpf_out [4];

  for (genvar g = 0; g < 4; g++)
  begin : g_hpf
    acp_highpass #(
      .FB (ACP_HPF_FB)
    ) u_hpf (
      .clk       (pclk),
      .rst_n     (presetn),
      .en        (hpf_en),
      .k         (hpf_k),
      .valid_in  (s1_valid),
      .din       (hpf_in[g]),
      .valid_out (hv[g]),
      .dout      (hpf_out[g])
    );
  end

  // ****************************************************************
  // Stage three: test patterns and output registers.
  // ****************************************************************

  logic [ACP_PRBS_W-1:0]    lfsr_r;
  logic [ACP_DW-1:0]        ramp_r;
  logic                     tog_r;
  logic                     out_valid_r;

  // Word for a pattern code; unused codes keep the sample data.
  function automatic logic [ACP_DW-1:0] pat_word(
    input logic [2:0]        code,
    input logic [ACP_DW-1:0] data,
    input logic [ACP_DW-1:0] ramp,
    input logic              tog);
    case (code)
      ACP_PAT_ZERO: return '0;
      ACP_PAT_ONES: return ACP_W_ONES;
      ACP_PAT_TOG:  return tog ? ACP_W_TOG_B : ACP_W_TOG_A;
      ACP_PAT_RAMP: return ramp;
      default:      return data;
    endcase
  endfunction

  // Pattern sources advance once per output sample.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lfsr_r <= ACP_PRBS_SEED;
      ramp_r <= '0;
      tog_r  <= 1'b0;
    end
    else if (hv[0])
    begin
      lfsr_r <= {lfsr_r[ACP_PRBS_W-2:0],
                 lfsr_r[ACP_PRBS_W-1] ^ lfsr_r[ACP_PRBS_TAP]};
      ramp_r <= ramp_r + 1'b1;
      tog_r  <= !tog_r;
    end
  end

  // PRBS outranks the coded pattern; both need the select bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid_r <= 1'b0;
      for (int i = 0; i < 4; i++)
        out_r[i] <= '0;
    end
    else
    begin
      out_valid_r <= hv[0];
      if (hv[0])
      begin
        for (int i = 0; i < 4; i++)
          out_r[i] <= hpf_out[i];
        if (pat_sel)
        begin
          out_r[0] <= pat_word(code5, hpf_out[0], ramp_r, tog_r);
          out_r[1] <= pat_word(code6, hpf_out[1], ramp_r, tog_r);
          for (int i = 0; i < 4; i++)
            if (prbs_en[i])
              out_r[i] <= lfsr_r[ACP_DW-1:0];
        end
      end
    end
  end

  assign out_valid = out_valid_r;
  assign out5_data = out_r[0];
  assign out6_data = out_r[1];
  assign out7_data = out_r[2];
  assign out8_data = out_r[3];

  // ****************************************************************
  // Checks.
  // ****************************************************************

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_answer;
    pready_r ##1 !pready_r;
  endsequence

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    s_setup |=> s_answer;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("bus answer not given in the access cycle");

  property p_copy;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && idx == ACP_IDX_OFS_COPY |=> ofs_copy_r == $past(wdata16);
  endproperty
  a_copy: assert property (p_copy)
    else $error("offset copy register did not take the write");

  property p_hpf_cfg;
    @(posedge pclk) disable iff (!presetn)
    wr_acc && idx == ACP_IDX_PAT_HPF
    |=> hpf_en == $past(wdata16[ACP_HPF_EN]) &&
        hpf_k == $past(wdata16[ACP_K_HI:ACP_K_LO]);
  endproperty
  a_hpf_cfg: assert property (p_hpf_cfg)
    else $error("filter enable or corner not updated");

  property p_prbs5;
    @(posedge pclk) disable iff (!presetn)
    hv[0] && pat_sel && prbs_en[0]
    |=> out_valid && out5_data == $past(lfsr_r[ACP_DW-1:0]);
  endproperty
  a_prbs5: assert property (p_prbs5)
    else $error("output 5 does not carry the PRBS word");

  property p_code5_zero;
    @(posedge pclk) disable iff (!presetn)
    hv[0] && pat_sel && !prbs_en[0] && code5 == ACP_PAT_ZERO
    |=> out5_data == '0;
  endproperty
  a_code5_zero: assert property (p_code5_zero)
    else $error("output 5 zero pattern not driven");

  property p_code6_ones;
    @(posedge pclk) disable iff (!presetn)
    hv[0] && pat_sel && !prbs_en[1] && code6 == ACP_PAT_ONES
    |=> out6_data == ACP_W_ONES;
  endproperty
  a_code6_ones: assert property (p_code6_ones)
    else $error("output 6 ones pattern not driven");

  property p_latency;
    @(posedge pclk) disable iff (!presetn)
    sample_valid |-> ##3 out_valid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("sample did not reach the outputs in three cycles");

endmodule // acp_chan_post

// ### acp_pkg.sv
package acp_pkg;

  // ****************************************************************
  // Data widths and arithmetic scaling.
  // ****************************************************************
  localparam int ACP_DW      = 14;
  localparam int ACP_GAIN_FB = 12;
  localparam int ACP_COEF_FB = 16;
  localparam int ACP_HPF_FB  = 6;
  localparam logic signed [31:0] ACP_MAX =
    (32'sh00000001 <<< (ACP_DW - 1)) - 32'sh00000001;
  localparam logic signed [31:0] ACP_MIN = -(ACP_MAX + 32'sh00000001);

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [5:0]  ACP_IDX_GAIN_OFS = 6'h1F;
  localparam logic [5:0]  ACP_IDX_OFS_COPY = 6'h20;
  localparam logic [5:0]  ACP_IDX_PAT_HPF  = 6'h21;
  localparam logic [5:0]  ACP_IDX_CTRL     = 6'h30;
  localparam logic [5:0]  ACP_IDX_STAT     = 6'h31;
  localparam logic [15:0] ACP_REG_RST      = 16'h0000;
  localparam logic [2:0]  ACP_CTRL_RST     = 3'h0;

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int ACP_GAIN_HI  = 15;
  localparam int ACP_GAIN_LO  = 11;
  localparam int ACP_OFS_HI   = 9;
  localparam int ACP_OFS_LO   = 0;
  localparam int ACP_PRBS5    = 15;
  localparam int ACP_PAT5_HI  = 11;
  localparam int ACP_PAT5_LO  = 9;
  localparam int ACP_PAT6_HI  = 8;
  localparam int ACP_PAT6_LO  = 6;
  localparam int ACP_K_HI     = 4;
  localparam int ACP_K_LO     = 1;
  localparam int ACP_HPF_EN   = 0;
  localparam int ACP_CTL_GAIN = 0;
  localparam int ACP_CTL_OFS  = 1;
  localparam int ACP_CTL_PSEL = 2;
  localparam int ACP_ST_MISM  = 15;

  // ****************************************************************
  // Test pattern codes, words and the PRBS generator.
  // ****************************************************************
  localparam logic [2:0]  ACP_PAT_DATA = 3'h0;
  localparam logic [2:0]  ACP_PAT_ZERO = 3'h1;
  localparam logic [2:0]  ACP_PAT_ONES = 3'h2;
  localparam logic [2:0]  ACP_PAT_TOG  = 3'h3;
  localparam logic [2:0]  ACP_PAT_RAMP = 3'h4;
  localparam logic [13:0] ACP_W_ONES   = 14'h3FFF;
  localparam logic [13:0] ACP_W_TOG_A  = 14'h2AAA;
  localparam logic [13:0] ACP_W_TOG_B  = 14'h1555;
  localparam int          ACP_PRBS_W   = 23;
  localparam int          ACP_PRBS_TAP = 17;
  localparam logic [22:0] ACP_PRBS_SEED = 23'h7FFFFF;

  // Clamps a wide signed value to the output sample range.
  function automatic logic signed [ACP_DW-1:0] acp_sat(
    input logic signed [31:0] v);
    if (v > ACP_MAX)
      return ACP_DW'(ACP_MAX);
    else if (v < ACP_MIN)
      return ACP_DW'(ACP_MIN);
    else
      return ACP_DW'(v);
  endfunction

endpackage

// ### acp_gain_offset.sv
`timescale 1ns/100ps
module acp_gain_offset
  import acp_pkg::*;
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     valid_in,
  input  wire logic signed [ACP_DW-1:0] din,
  input  wire logic                     gain_en,
  input  wire logic                     ofs_en,
  input  wire logic [4:0]               gain_code,
  input  wire logic [9:0]               ofs,
  output logic                          valid_out,
  output logic signed [ACP_DW-1:0]      dout
);

  localparam logic signed [31:0] RND = 32'sh00000001 <<< (ACP_GAIN_FB-1);

  // Linear factor of code times 0.2 dB, with twelve fraction bits.
  function automatic logic [13:0] gain_lin(input logic [4:0] n);
    case (n)
      5'h00: return 14'h1000; 5'h01: return 14'h105F;
      5'h02: return 14'h10C1; 5'h03: return 14'h1125;
      5'h04: return 14'h118B; 5'h05: return 14'h11F4;
      5'h06: return 14'h125F; 5'h07: return 14'h12CC;
      5'h08: return 14'h133C; 5'h09: return 14'h13AF;
      5'h0A: return 14'h1425; 5'h0B: return 14'h149D;
      5'h0C: return 14'h1518; 5'h0D: return 14'h1595;
      5'h0E: return 14'h1616; 5'h0F: return 14'h169A;
      5'h10: return 14'h1720; 5'h11: return 14'h17AA;
      5'h12: return 14'h1838; 5'h13: return 14'h18C8;
      5'h14: return 14'h195C; 5'h15: return 14'h19F3;
      5'h16: return 14'h1A8E; 5'h17: return 14'h1B2C;
      5'h18: return 14'h1BCE; 5'h19: return 14'h1C74;
      5'h1A: return 14'h1D1D; 5'h1B: return 14'h1DCB;
      5'h1C: return 14'h1E7D; 5'h1D: return 14'h1F33;
      5'h1E: return 14'h1FEC; default: return 14'h20AB;
    endcase
  endfunction

  logic signed [31:0] scaled;
  logic signed [31:0] sum;

  // Scales with rounding, then adds the signed offset.
  always_comb
  begin
    scaled = (32'(din) * 32'($signed({1'b0, gain_lin(gain_code)}))
              + RND) >>> ACP_GAIN_FB;
    sum = gain_en ? scaled : 32'(din);
    if (ofs_en)
      sum = sum + 32'($signed(ofs));
  end

  // Registers the corrected sample.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid_out <= 1'b0;
      dout      <= '0;
    end
    else
    begin
      valid_out <= valid_in;
      if (valid_in)
        dout <= acp_sat(sum);
    end
  end

  property p_unity;
    @(posedge clk) disable iff (!rst_n)
    valid_in && !ofs_en && (!gain_en || gain_code == 5'h00)
    |=> valid_out && dout == $past(din);
  endproperty
  a_unity: assert property (p_unity)
    else $error("unity gain path altered the sample");

  property p_offset;
    @(posedge clk) disable iff (!rst_n)
    valid_in && !gain_en && ofs_en && din < 14'sh1C00 && din > -14'sh1C00
    |=> 32'(dout) == 32'($past(din)) + 32'($signed($past(ofs)));
  endproperty
  a_offset: assert property (p_offset)
    else $error("offset not added to the sample");

endmodule // acp_gain_offset

// ### acp_highpass.sv
`timescale 1ns/100ps
module acp_highpass
  import acp_pkg::*;
#(
  parameter int FB = ACP_HPF_FB
)
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     en,
  input  wire logic [3:0]               k,
  input  wire logic                     valid_in,
  input  wire logic signed [ACP_DW-1:0] din,
  output logic                          valid_out,
  output logic signed [ACP_DW-1:0]      dout
);

  localparam int E = ACP_DW + FB + 2;
  localparam logic signed [63:0] CRND =
    64'sh0000000000000001 <<< (ACP_COEF_FB - 1);
  localparam logic signed [31:0] ORND = 32'sh00000001 <<< (FB - 1);

  // Factor 2^k/(2^k+1) with sixteen fraction bits, every code covered.
  function automatic logic [15:0] coef(input logic [3:0] kk);
    case (kk)
      4'h0: return 16'h8000; 4'h1: return 16'hAAAB;
      4'h2: return 16'hCCCD; 4'h3: return 16'hE38E;
      4'h4: return 16'hF0F0; 4'h5: return 16'hF83E;
      4'h6: return 16'hFC10; 4'h7: return 16'hFE04;
      4'h8: return 16'hFF01; 4'h9: return 16'hFF80;
      4'hA: return 16'hFFC0; 4'hB: return 16'hFFE0;
      4'hC: return 16'hFFF0; 4'hD: return 16'hFFF8;
      4'hE: return 16'hFFFC; default: return 16'hFFFE;
    endcase
  endfunction

  logic signed [ACP_DW-1:0] xp_r;
  logic signed [E-1:0]      yp_r;
  logic signed [63:0]       s;
  logic signed [63:0]       prod;
  logic signed [31:0]       y_nxt;

  // Computes y(n) from x(n), x(n-1) and y(n-1) with fraction bits.
  always_comb
  begin
    s = (64'(din) <<< FB) - (64'(xp_r) <<< FB) + 64'(yp_r);
    prod = s * 64'($signed({1'b0, coef(k)}));
    y_nxt = 32'((prod + CRND) >>> ACP_COEF_FB);
  end

  // Keeps the filter state and rounds the result to the sample width.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xp_r      <= '0;
      yp_r      <= '0;
      valid_out <= 1'b0;
      dout      <= '0;
    end
    else
    begin
      valid_out <= valid_in;
      if (!en)
      begin
        xp_r <= '0;
        yp_r <= '0;
        if (valid_in)
          dout <= din;
      end
      else if (valid_in)
      begin
        xp_r <= din;
        yp_r <= y_nxt[E-1:0];
        dout <= acp_sat((y_nxt + ORND) >>> FB);
      end
    end
  end

  property p_bypass;
    @(posedge clk) disable iff (!rst_n)
    !en && valid_in |=> valid_out && dout == $past(din);
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("disabled filter did not pass the sample");

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    !en |=> xp_r == '0 && yp_r == '0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("filter state not cleared while disabled");

  property p_flat;
    @(posedge clk) disable iff (!rst_n)
    en && valid_in && din == xp_r && yp_r == '0 |=> dout == '0;
  endproperty
  a_flat: assert property (p_flat)
    else $error("flat input from rest gave nonzero output");

endmodule // acp_highpass

// ### acp_rx_model.sv
`timescale 1ns/100ps
// ********
// Receiver model: latches each sample set handed over on the lanes.
// ********
module acp_rx_model
  import acp_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                vld,
  input  wire logic [4*ACP_DW-1:0] din,
  output logic [4*ACP_DW-1:0]      cap,
  output int unsigned              cnt
);
  // Capture one set per valid pulse and count the sets.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cap <= '0;
      cnt <= 0;
    end
    else if (vld)
    begin
      cap <= din;
      cnt <= cnt + 1;
    end
  end
endmodule // acp_rx_model

// ### acp_chan_post_tb.sv
`timescale 1ns/100ps
module acp_chan_post_tb;
  import acp_pkg::*;
  // ********
  // Signals.
  // ********
  logic                     pclk, presetn, psel, penable, pwrite, pready;
  logic                     pslverr, sample_valid, out_valid, rerr;
  logic [7:0]               paddr;
  logic [31:0]              pwdata, prdata, rdat;
  logic signed [ACP_DW-1:0] s5, s6, s7, s8, o5, o6, o7, o8;
  logic [4*ACP_DW-1:0]      cap;
  int unsigned              cnt;
  int                       errors, n_checks;

  acp_chan_post DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sample_valid), .chan5_sample(s5), .chan6_sample(s6),
    .chan7_sample(s7), .chan8_sample(s8), .out_valid(out_valid),
    .out5_data(o5), .out6_data(o6), .out7_data(o7), .out8_data(o8));
  acp_rx_model RX (.clk(pclk), .rst_n(presetn), .vld(out_valid),
    .din({o8, o7, o6, o5}), .cap(cap), .cnt(cnt));

  // Clock of 8 ns.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ********
  // Shared tasks.
  // ********
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Compares a value against an expectation within a tolerance.
  task chk(input logic [31:0] got, input int exp, input int tol);
    logic ok;
    ok = 1'b0;
    n_checks++;
    for (int i = -tol; i <= tol; i++)
      if (got === 32'(exp + i) || got === 32'(ACP_DW'(exp + i))) ok = 1'b1;
    if (!ok)
    begin
      errors++;
      $display("ERROR %0t got %h expected %0d", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for pready under a bound.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(0, 1, 0);
  endtask
  // Reads a register and checks data and error flag.
  task rdc(input logic [7:0] a, input int x, input int e);
    apb(1'b0, a, 32'h0);
    chk(rdat, x, 0);
    chk({31'h0, rerr}, e, 0);
  endtask
  // Sends one sample set and waits for the receiver to latch the result.
  task send(input int a, input int b, input int c, input int d);
    int unsigned c0;
    int n;
    c0 = cnt;
    n = 0;
    @(posedge pclk);
    sample_valid <= 1'b1;
    {s5, s6, s7, s8} <= {14'(a), 14'(b), 14'(c), 14'(d)};
    @(posedge pclk);
    sample_valid <= 1'b0;
    while (cnt == c0 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (cnt == c0) chk(0, 1, 0);
  endtask
  // Sign-extends one captured lane so negative samples compare correctly.
  function automatic logic [31:0] lane(input int i);
    return 32'($signed(cap[i*ACP_DW +: ACP_DW]));
  endfunction
  // Expected PRBS word after n steps of the generator from its seed.
  function automatic int prbs(input int n);
    logic [ACP_PRBS_W-1:0] r;
    r = ACP_PRBS_SEED;
    for (int i = 0; i < n; i++)
      r = {r[ACP_PRBS_W-2:0], r[ACP_PRBS_W-1] ^ r[ACP_PRBS_TAP]};
    return int'(r[ACP_DW-1:0]);
  endfunction
  // Checks all four lanes against expectations.
  task lanes(input int a, input int b, input int c, input int d, input int t);
    chk(lane(0), a, t);
    chk(lane(1), b, t);
    chk(lane(2), c, t);
    chk(lane(3), d, t);
  endtask
  // ********
  // Scenarios.
  // ********
  task t_regs;
    rdc(8'h7C, 0, 0);
    rdc(8'h84, 0, 0);
    rdc(8'hF0, 0, 1);
    apb(1'b1, 8'h7C, 32'h2BFB);
    apb(1'b1, 8'h80, 32'h03FB);
    rdc(8'h7C, 32'h2BFB, 0);
    rdc(8'h80, 32'h03FB, 0);
  endtask
  task t_chan8;
    send(100, -200, 300, 1000);
    lanes(100, -200, 300, 1000, 0);
    apb(1'b1, 8'hC0, 32'h3);
    send(1, 2, 3, 1000);
    chk(lane(3), 1117, 1);
    apb(1'b1, 8'hC0, 32'h2);
    send(1, 2, 3, 1000);
    chk(lane(3), 995, 0);
    rdc(8'hC4, 995, 0);
  endtask
  task t_pattern;
    apb(1'b1, 8'hC0, 32'h4);
    apb(1'b1, 8'h84, 32'h0280);
    send(11, 22, 33, 44);
    lanes(0, 16'h3FFF, 33, 44, 0);
    apb(1'b1, 8'h84, 32'h5000);
    send(11, 22, 33, 44);
    lanes(11, prbs(cnt - 1), 33, prbs(cnt - 1), 0);
    apb(1'b1, 8'h84, 32'hA000);
    send(11, 22, 33, 44);
    lanes(prbs(cnt - 1), 22, prbs(cnt - 1), 44, 0);
    apb(1'b1, 8'h84, 32'h08C0);
    send(11, 22, 33, 44);
    lanes(cnt - 1, (cnt % 2) ? ACP_W_TOG_A : ACP_W_TOG_B, 33, 44, 0);
  endtask
  task t_hpf;
    apb(1'b1, 8'hC0, 32'h0);
    apb(1'b1, 8'h84, 32'h0005);
    send(0, 0, 0, 0);
    lanes(0, 0, 0, 0, 0);
    send(1000, 1000, 1000, 1000);
    lanes(800, 800, 800, 800, 1);
    send(1000, 1000, 1000, 1000);
    lanes(640, 640, 640, 640, 1);
    apb(1'b1, 8'h84, 32'h0004);
    send(1000, 1000, 1000, 1000);
    lanes(1000, 1000, 1000, 1000, 0);
    apb(1'b1, 8'h84, 32'h0005);
    send(1000, 1000, 1000, 1000);
    lanes(800, 800, 800, 800, 1);
  endtask
  // Main sequence after a 20-cycle reset.
  initial
  begin
    {presetn, psel, penable, pwrite, sample_valid} = 5'h00;
    {paddr, pwdata, s5, s6, s7, s8} = '0;
    errors = 0;
    n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_chan8();
    t_pattern();
    t_hpf();
    give_verdict();
  end
  // Watchdog well past the expected run length.
  initial
  begin
    repeat (5000) @(posedge pclk);
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // acp_chan_post_tb
